// >>> dv/tiat_properties.sv
// concurrent checks on the trigger link between camera and trigger source
`timescale 1ns/1ns
module tiat_properties (
   input wire logic i_clk,         // clock
   input wire logic i_rst_b,       // async reset, active low
   input wire logic trig,          // trigger pulse
   input wire logic trig_wait,     // trigger accept window
   input wire logic frame_active,  // frame busy flag
   input wire logic expo_ttl,      // logic-level exposure
   input wire logic expo_spare,    // spare link bit exposure
   input wire logic fval,          // frame valid
   input wire logic lnk_clk        // link clock
);
   // ---------------------------------------------------------------
   // cycles since exposure end
   // ---------------------------------------------------------------
   logic [15:0] gap_reg;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b)
         gap_reg <= 16'h0;
      else if ($fell(expo_ttl))
         gap_reg <= 16'h1;
      else if (gap_reg != 16'h0 && gap_reg != 16'hffff)
         gap_reg <= gap_reg + 16'h1;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   sequence frame_start;
      $rose(frame_active) && $rose(expo_ttl);
   endsequence
   expo_with_frame_a: assert property ($rose(expo_ttl) |-> frame_start)
      else $error("exposure rose apart from frame flag");
   busy_after_wait_a: assert property ($fell(trig_wait) && !fval |-> ##29 frame_start)
      else $error("frame flag not 29 cycles after window close");
   busy_end_a: assert property ($fell(frame_active) |->
      ($past(fval, 28) && !$past(fval, 27)) || ($past(fval, 11) && !$past(fval, 10)))
      else $error("frame flag fell at wrong distance from fval");
   wait_rearm_a: assert property ($rose(trig_wait) && !fval |->
      $past(frame_active, 26) && !$past(frame_active, 25))
      else $error("window reopened at wrong time");
   wait_drop_a: assert property ($fell(trig_wait) && !fval |->
      $past(trig, 20) && !$past(trig, 30))
      else $error("window closed at wrong distance from trigger");
   spare_lead_a: assert property ($rose(expo_ttl) |->
      $past(expo_spare, 25) && !$past(expo_spare, 45))
      else $error("spare exposure lead wrong");
   spare_end_a: assert property ($fell(expo_ttl) |->
      $past(expo_spare, 7) && !$past(expo_spare, 6))
      else $error("spare exposure end phase wrong");
   fval_gap_a: assert property ($rose(fval) |-> gap_reg inside
      {[16'd7990:16'd8030], [16'd8190:16'd8230], [16'd16390:16'd16430]})
      else $error("fval start gap wrong");
   link_clk_a: assert property ($rose(lnk_clk) |-> ##8 $rose(lnk_clk))
      else $error("link clock period wrong");
endmodule

// >>> dv/trigger_interval_and_io_timing_bench.sv
// self-checking bench: camera sequencer and trigger source joined by the link
`timescale 1ns/1ns
module trigger_interval_and_io_timing_bench;
   import tiat_pkg::*;
   // ---------------------------------------------------------------
   // stimulus, instances and helpers
   // ---------------------------------------------------------------
   logic clk, rst_b, c60, bin, ovl, ign, wr, rd, busy;
   tiat_layout_t lay;
   logic [15:0] hgt, wid;
   logic [23:0] expo, min_us;
   logic [4:0] addr;
   logic [31:0] wdata, rdata;
   int mismatches = 0;
   int n_tests = 0;
   int k;
   real cn[4] = '{1309.27, 1318.61, 2618.54, 2637.25};
   real cb[4] = '{2618.53, 2637.23, 5237.09, 5274.49};
   int o1[4] = '{339, 452, 667, 892};
   int o2[4] = '{266, 353, 521, 696};
   tiat_if lnk();
   tiat_dev tiat_dev_inst (.i_clk(clk), .i_rst_b(rst_b), .i_ce(1'b1), .lnk(lnk),
      .i_layout(lay), .i_clk60(c60), .i_binning(bin), .i_overlap(ovl), .i_height(hgt),
      .i_width(wid), .i_expo_us(expo), .o_min_us(min_us), .o_busy(busy), .o_ignored(ign));
   tiat_host tiat_host_inst (.i_clk(clk), .i_rst_b(rst_b), .i_ce(1'b1), .lnk(lnk),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata));
   tiat_properties tiat_properties_inst (.i_clk(clk), .i_rst_b(rst_b), .trig(lnk.trig),
      .trig_wait(lnk.trig_wait), .frame_active(lnk.frame_active), .expo_ttl(lnk.expo_ttl),
      .expo_spare(lnk.expo_spare), .fval(lnk.fval), .lnk_clk(lnk.lnk_clk));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   function automatic logic sg(input int i);
      case (i)
         0: return lnk.trig_wait;
         1: return lnk.fval;
         2: return lnk.expo_ttl;
         default: return ign;
      endcase
   endfunction
   // waits for a link signal or o_ignored to reach a level, a miss counts as a mismatch
   task automatic wt(input int i, input logic v, input int lim);
      for (k = 0; k < lim && sg(i) !== v; k++) begin
         @(posedge clk);
         #1;
      end
      chk(sg(i), v);
   endtask
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
   endtask
   function automatic int exp_min(input int i, input bit b, input int e);
      real f;
      int fr;
      f = ((hgt + 1) * (b ? cb[i] : cn[i]) - (b ? (i > 1 ? 2560.0 : 1280.0) : cn[i])
         + wid / (i > 1 ? 2.0 : 4.0)) / (i % 2 ? 60.0 : 80.0);
      fr = $rtoi(f + 0.5);
      return e > fr ? o2[i] + e : fr + o1[i];
   endfunction
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic s_formula;
      for (int i = 0; i < 8; i++) begin
         for (int e = 0; e < 2; e++) begin
            @(posedge clk);
            lay <= i[2] ? TIAT_TWO : TIAT_FOUR;
            c60 <= i[0];
            bin <= i[1];
            expo <= e ? 24'd20000 : 24'd1;
            repeat (3) @(posedge clk);
            #1;
            chk(min_us, exp_min({i[2], i[0]}, i[1], e ? 20000 : 1));
         end
      end
   endtask
   task automatic s_sequence;
      bus(1'b1, 5'h00, 32'h5);
      wt(0, 1'b0, 100);
      wt(2, 1'b1, 100);
      chk(busy, 1'b1);
      wt(2, 1'b0, 200);
      wt(1, 1'b1, 8300);
      chk(k >= 8150 && k <= 8230, 1'b1);
      wt(1, 1'b0, 500);
      wt(0, 1'b1, 100);
      bus(1'b0, 5'h10, 32'h0);
      chk(rdata, 32'h1);
      bus(1'b0, 5'h14, 32'h0);
      chk(rdata, 32'd50);
      bus(1'b0, 5'h1c, 32'h0);
      chk(rdata, 32'h0);
      bus(1'b1, 5'h00, 32'h5);
      wt(3, 1'b1, 200);
      chk(lnk.trig_wait, 1'b1);
      repeat (400) @(posedge clk);
      bus(1'b1, 5'h00, 32'h5);
      wt(0, 1'b0, 100);
      wt(0, 1'b1, 10000);
      chk(busy, 1'b0);
   endtask
   // auto triggers spaced by longest exposure plus guard, not by the shorter period
   task automatic s_auto;
      int k1;
      @(posedge clk);
      lay <= TIAT_EIGHT;
      bus(1'b0, 5'h0c, 32'h0);
      chk(rdata & 32'h7, 32'h1);
      bus(1'b1, 5'h08, 32'd134);
      bus(1'b1, 5'h04, 32'd1);
      bus(1'b0, 5'h08, 32'h0);
      chk(rdata, 32'd134);
      bus(1'b1, 5'h00, 32'h6);
      wt(0, 1'b0, 2000);
      wt(0, 1'b1, 10000);
      k1 = k;
      wt(0, 1'b0, 3000);
      chk(k1 + k >= 9970 && k1 + k <= 10010, 1'b1);
      bus(1'b1, 5'h00, 32'h4);
      wt(0, 1'b1, 10000);
   endtask
   task automatic s_overlap;
      @(posedge clk);
      ovl <= 1'b1;
      expo <= 24'd40;
      hgt <= 16'd4;
      repeat (2000) @(posedge clk);
      bus(1'b1, 5'h00, 32'h5);
      wt(0, 1'b0, 100);
      wt(1, 1'b1, 10000);
      chk(lnk.trig_wait, 1'b1);
      repeat (1250) @(posedge clk);
      bus(1'b1, 5'h00, 32'h5);
      wt(0, 1'b0, 100);
      chk(lnk.fval, 1'b1);
      wt(1, 1'b0, 2000);
      wt(2, 1'b1, 100);
   endtask
   initial begin
      rst_b = 1'b0;
      {c60, bin, ovl, wr, rd} = '0;
      lay = TIAT_FOUR;
      hgt = 16'd100;
      wid = 16'd400;
      expo = 24'd1;
      addr = 5'h0;
      wdata = 32'h0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      s_formula;
      @(posedge clk);
      {c60, bin} <= 2'b00;
      lay <= TIAT_FOUR;
      hgt <= 16'd1;
      wid <= 16'd0;
      expo <= 24'd2;
      s_sequence;
      s_auto;
      s_overlap;
      stop_test;
   end
   initial begin
      repeat (80000) @(posedge clk);
      mismatches++;
      stop_test;
   end
endmodule

// >>> include/tiat_if.sv
// link between the camera sequencer and the trigger source / grabber
`timescale 1ns/1ns
interface tiat_if;
   logic trig;
   logic trig_wait;
   logic frame_active;
   logic expo_ttl;
   logic expo_spare;
   logic fval;
   logic lnk_clk;
   modport dev  (input trig, output trig_wait, frame_active, expo_ttl, expo_spare, fval,
                 lnk_clk);
   modport host (output trig, input trig_wait, frame_active, expo_ttl, expo_spare, fval,
                 lnk_clk);
endinterface

// >>> include/tiat_map.svh
// timing figures, formula coefficients and register offsets for the trigger sequencer
`ifndef TIAT_MAP_SVH
`define TIAT_MAP_SVH
// ---------------------------------------------------------------
// clock and conversion
// ---------------------------------------------------------------
`define TIAT_CLK_NS      40
`define TIAT_CYC(ns)     ((ns) / `TIAT_CLK_NS)
`define TIAT_US_CYC      (1000 / `TIAT_CLK_NS)
// ---------------------------------------------------------------
// sequence delays
// ---------------------------------------------------------------
`define TIAT_TW4_NS      820
`define TIAT_TW2_NS      1010
`define TIAT_BUSY_NS     1190
`define TIAT_REARM_NS    1000
`define TIAT_TAIL4_NS    1110
`define TIAT_TAIL2_NS    410
`define TIAT_SP4_NS      470
`define TIAT_SP2_NS      660
`define TIAT_SPEND_NS    240
`define TIAT_GAP8_US     24'd320
`define TIAT_GAP4_US     24'd328
`define TIAT_GAP2_US     24'd656
`define TIAT_LNK_HALF_NS 160
`define TIAT_PULSE_NS    1000
// ---------------------------------------------------------------
// interval formula, coefficients in hundredths
// ---------------------------------------------------------------
`define TIAT_C4_80       40'd130927
`define TIAT_B4_80       40'd261853
`define TIAT_C4_60       40'd131861
`define TIAT_B4_60       40'd263723
`define TIAT_C2_80       40'd261854
`define TIAT_B2_80       40'd523709
`define TIAT_C2_60       40'd263725
`define TIAT_B2_60       40'd527449
`define TIAT_S4_BIN      40'd128000
`define TIAT_S2_BIN      40'd256000
`define TIAT_W4_MUL      40'd25
`define TIAT_W2_MUL      40'd50
`define TIAT_DEN80       40'd8000
`define TIAT_DEN60       40'd6000
`define TIAT_O4_80       24'd339
`define TIAT_O4_60       24'd452
`define TIAT_O2_80       24'd667
`define TIAT_O2_60       24'd892
`define TIAT_X4_80       24'd266
`define TIAT_X4_60       24'd353
`define TIAT_X2_80       24'd521
`define TIAT_X2_60       24'd696
// ---------------------------------------------------------------
// controller registers
// ---------------------------------------------------------------
`define TIAT_A_CTRL      5'h00
`define TIAT_A_PERIOD    5'h04
`define TIAT_A_EXPMAX    5'h08
`define TIAT_A_STATUS    5'h0c
`define TIAT_A_FRAMES    5'h10
`define TIAT_A_LINKCNT   5'h14
// control word fields
`define TIAT_F_FIRE      0
`define TIAT_F_AUTO      1
`define TIAT_F_LAYOUT    3:2
`define TIAT_F_CLK60     4
`endif

// >>> include/tiat_pkg.sv
// layout type shared by both ends of the trigger link, state type used by the camera end only
package tiat_pkg;
   typedef enum logic [1:0] {TIAT_EIGHT, TIAT_FOUR, TIAT_TWO} tiat_layout_t;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ARM, ST_PRE, ST_EXPO, ST_GAP, ST_FVAL, ST_TAIL, ST_REARM
   } tiat_state_t;
endpackage

// >>> rtl/tiat_dev.sv
// camera end: trigger acceptance, interval check and exposure sequencing
`timescale 1ns/1ns
`include "tiat_map.svh"
module tiat_dev
   import tiat_pkg::*;
(
   input  wire logic         i_clk,      // 25 MHz clock
   input  wire logic         i_rst_b,    // async reset, active low
   input  wire logic         i_ce,       // clock enable
   tiat_if.dev               lnk,        // link to trigger source and grabber
   input  wire tiat_layout_t i_layout,   // lane layout
   input  wire logic         i_clk60,    // 1: 60 MHz pixel clock, 0: 80 MHz
   input  wire logic         i_binning,  // vertical binning on
   input  wire logic         i_overlap,  // 1: readout overlap, 0: off
   input  wire logic [15:0]  i_height,   // image height
   input  wire logic [15:0]  i_width,    // image width
   input  wire logic [23:0]  i_expo_us,  // exposure time in us
   output logic      [23:0]  o_min_us,   // minimum trigger interval in us
   output logic              o_busy,     // sequence running
   output logic              o_ignored   // one-cycle pulse: trigger masked
);
   // ---------------------------------------------------------------
   // interval formula
   // ---------------------------------------------------------------
   logic        two;
   logic [39:0] coef;
   logic [39:0] sub;
   logic [39:0] num;
   logic [39:0] den;
   logic [23:0] off1;
   logic [23:0] off2;
   logic [23:0] min_next;
   logic [23:0] frame_us_reg;
   logic [23:0] min_us_reg;

   assign two  = (i_layout == TIAT_TWO);
   assign coef = two ? (i_clk60 ? (i_binning ? `TIAT_B2_60 : `TIAT_C2_60)
                                : (i_binning ? `TIAT_B2_80 : `TIAT_C2_80))
                     : (i_clk60 ? (i_binning ? `TIAT_B4_60 : `TIAT_C4_60)
                                : (i_binning ? `TIAT_B4_80 : `TIAT_C4_80));
   assign sub  = i_binning ? (two ? `TIAT_S2_BIN : `TIAT_S4_BIN) : coef;
   assign num  = ({24'h000000, i_height} + 40'h1) * coef - sub
               + {24'h000000, i_width} * (two ? `TIAT_W2_MUL : `TIAT_W4_MUL);
   assign den  = i_clk60 ? `TIAT_DEN60 : `TIAT_DEN80;
   assign off1 = two ? (i_clk60 ? `TIAT_O2_60 : `TIAT_O2_80)
                     : (i_clk60 ? `TIAT_O4_60 : `TIAT_O4_80);
   assign off2 = two ? (i_clk60 ? `TIAT_X2_60 : `TIAT_X2_80)
                     : (i_clk60 ? `TIAT_X4_60 : `TIAT_X4_80);
   // exposure longer than one frame switches to the exposure-based bound
   assign min_next = (i_expo_us > frame_us_reg) ? off2 + i_expo_us
                                                : frame_us_reg + off1;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         frame_us_reg <= 24'h000000;
         min_us_reg   <= 24'h000000;
      end else if (i_ce) begin
         frame_us_reg <= 24'((num + (den >> 1)) / den);
         min_us_reg   <= min_next;
      end
   end

   // ---------------------------------------------------------------
   // trigger synchroniser and acceptance
   // ---------------------------------------------------------------
   logic        trig_s1_reg;
   logic        trig_s2_reg;
   logic        trig_s3_reg;
   logic        trig_rise;
   logic        ival_ok;
   logic        window;
   logic        accept;
   logic [23:0] ival_reg;
   logic [4:0]  ipre_reg;
   logic        itick;
   logic        pend_reg;
   tiat_state_t state_reg;
   tiat_state_t state_next;

   assign trig_rise = trig_s2_reg & ~trig_s3_reg;
   assign ival_ok   = (ival_reg >= min_us_reg);
   assign window    = (state_reg == ST_IDLE)
                    | (i_overlap & (state_reg == ST_FVAL) & ~pend_reg);
   assign accept    = trig_rise & ival_ok & window;
   // free-running so the interval count loses no time at state changes
   assign itick     = (ipre_reg == 5'(`TIAT_US_CYC - 1));

   // ---------------------------------------------------------------
   // sequence timing
   // ---------------------------------------------------------------
   logic [23:0] cnt_reg;
   logic [4:0]  pre_reg;
   logic [23:0] ucnt_reg;
   logic        tick;
   logic [23:0] t_tw;
   logic [23:0] t_busy;
   logic [23:0] t_sp;
   logic [23:0] t_tail;
   logic [23:0] t_rearm;
   logic [23:0] t_gap;
   logic [23:0] t_exp;
   logic [23:0] t_spend;
   logic        arm_end;
   logic        pre_end;
   logic        exp_end;
   logic        gap_end;
   logic        fval_end;
   logic        tail_end;
   logic        rearm_end;

   assign tick    = (pre_reg == 5'(`TIAT_US_CYC - 1));
   assign t_tw    = two ? 24'(`TIAT_CYC(`TIAT_TW2_NS)) : 24'(`TIAT_CYC(`TIAT_TW4_NS));
   assign t_busy  = 24'(`TIAT_CYC(`TIAT_BUSY_NS));
   assign t_sp    = two ? 24'(`TIAT_CYC(`TIAT_SP2_NS)) : 24'(`TIAT_CYC(`TIAT_SP4_NS));
   assign t_tail  = two ? 24'(`TIAT_CYC(`TIAT_TAIL2_NS)) : 24'(`TIAT_CYC(`TIAT_TAIL4_NS));
   assign t_rearm = 24'(`TIAT_CYC(`TIAT_REARM_NS));
   assign t_gap   = two ? `TIAT_GAP2_US
                        : ((i_layout == TIAT_EIGHT) ? `TIAT_GAP8_US : `TIAT_GAP4_US);
   assign t_exp   = 24'(i_expo_us * 24'(`TIAT_US_CYC));
   assign t_spend = 24'(`TIAT_CYC(`TIAT_SPEND_NS));

   assign arm_end   = (state_reg == ST_ARM)   & (cnt_reg == t_tw - 24'h1);
   assign pre_end   = (state_reg == ST_PRE)   & (cnt_reg == t_busy - 24'h1);
   assign exp_end   = (state_reg == ST_EXPO)  & (cnt_reg + 24'h1 >= t_exp);
   assign gap_end   = (state_reg == ST_GAP)   & tick & (ucnt_reg == t_gap - 24'h1);
   assign fval_end  = (state_reg == ST_FVAL)  & tick & (ucnt_reg + 24'h1 >= frame_us_reg);
   assign tail_end  = (state_reg == ST_TAIL)  & (cnt_reg == t_tail - 24'h1);
   assign rearm_end = (state_reg == ST_REARM) & (cnt_reg == t_rearm - 24'h1);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:  if (accept)    state_next = ST_ARM;
         ST_ARM:   if (arm_end)   state_next = ST_PRE;
         ST_PRE:   if (pre_end)   state_next = ST_EXPO;
         ST_EXPO:  if (exp_end)   state_next = ST_GAP;
         ST_GAP:   if (gap_end)   state_next = ST_FVAL;
         ST_FVAL:  if (fval_end)  state_next = ST_TAIL;
         ST_TAIL:  if (tail_end)  state_next = pend_reg ? ST_PRE : ST_REARM;
         ST_REARM: if (rearm_end) state_next = ST_IDLE;
         default:                 state_next = ST_IDLE;
      endcase
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   logic tw_reg;
   logic fa_reg;
   logic ettl_reg;
   logic espare_reg;
   logic fval_reg;
   logic lnk_clk_reg;
   logic [2:0] div_reg;
   logic ign_reg;
   logic busy_reg;

   assign lnk.trig_wait    = tw_reg;
   assign lnk.frame_active = fa_reg;
   assign lnk.expo_ttl     = ettl_reg;
   assign lnk.expo_spare   = espare_reg;
   assign lnk.fval         = fval_reg;
   assign lnk.lnk_clk      = lnk_clk_reg;
   assign o_min_us         = min_us_reg;
   assign o_ignored        = ign_reg;
   assign o_busy           = busy_reg;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         trig_s1_reg <= 1'b0;
         trig_s2_reg <= 1'b0;
         trig_s3_reg <= 1'b0;
         state_reg   <= ST_IDLE;
         cnt_reg     <= 24'h000000;
         pre_reg     <= 5'h00;
         ucnt_reg    <= 24'h000000;
         ival_reg    <= 24'hffffff;
         ipre_reg    <= 5'h00;
         pend_reg    <= 1'b0;
         ign_reg     <= 1'b0;
         busy_reg    <= 1'b0;
      end else if (i_ce) begin
         trig_s1_reg <= lnk.trig;
         trig_s2_reg <= trig_s1_reg;
         trig_s3_reg <= trig_s2_reg;
         state_reg   <= state_next;
         ign_reg     <= trig_rise & ~accept;
         busy_reg    <= (state_next != ST_IDLE);
         if (state_next != state_reg) begin
            cnt_reg  <= 24'h000000;
            pre_reg  <= 5'h00;
            ucnt_reg <= 24'h000000;
         end else begin
            cnt_reg  <= cnt_reg + 24'h1;
            pre_reg  <= tick ? 5'h00 : pre_reg + 5'h1;
            if (tick)
               ucnt_reg <= ucnt_reg + 24'h1;
         end
         ipre_reg <= itick ? 5'h00 : ipre_reg + 5'h1;
         if (accept)
            ival_reg <= 24'h000000;
         else if (itick && ival_reg != 24'hffffff)
            ival_reg <= ival_reg + 24'h1;
         if (accept && state_reg == ST_FVAL)
            pend_reg <= 1'b1;
         else if (tail_end)
            pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tw_reg      <= 1'b1;
         fa_reg      <= 1'b0;
         ettl_reg    <= 1'b0;
         espare_reg  <= 1'b0;
         fval_reg    <= 1'b0;
         lnk_clk_reg <= 1'b0;
         div_reg     <= 3'h0;
      end else if (i_ce) begin
         if (arm_end || (accept && state_reg == ST_FVAL))
            tw_reg <= 1'b0;
         else if (rearm_end || (gap_end && i_overlap))
            tw_reg <= 1'b1;
         if (pre_end) begin
            fa_reg   <= 1'b1;
            ettl_reg <= 1'b1;
         end
         if (tail_end)
            fa_reg <= 1'b0;
         if (exp_end)
            ettl_reg <= 1'b0;
         if (((state_reg == ST_ARM) && cnt_reg == t_sp - 24'h1) ||
             ((state_reg == ST_TAIL) && tail_end && pend_reg))
            espare_reg <= 1'b1;
         else if ((state_reg == ST_EXPO) && (cnt_reg + t_spend + 24'h1 >= t_exp))
            espare_reg <= 1'b0;
         if (gap_end)
            fval_reg <= 1'b1;
         else if (fval_end)
            fval_reg <= 1'b0;
         // pixel clock stand-in, period 8 cycles
         if (div_reg == 3'(`TIAT_CYC(`TIAT_LNK_HALF_NS) - 1)) begin
            div_reg     <= 3'h0;
            lnk_clk_reg <= ~lnk_clk_reg;
         end else begin
            div_reg <= div_reg + 3'h1;
         end
      end
   end
endmodule

// >>> rtl/tiat_host.sv
// far end: trigger source with period guard and frame grabber status
`timescale 1ns/1ns
`include "tiat_map.svh"
module tiat_host
   import tiat_pkg::*;
(
   input  wire logic        i_clk,    // 25 MHz clock
   input  wire logic        i_rst_b,  // async reset, active low
   input  wire logic        i_ce,     // clock enable
   tiat_if.host             lnk,      // link to the camera
   input  wire logic [4:0]  i_addr,   // register byte address
   input  wire logic [31:0] i_wdata,  // write data
   input  wire logic        i_wr,     // write strobe
   input  wire logic        i_rd,     // read strobe
   output logic      [31:0] o_rdata   // read data, cycle after i_rd
);
   // ---------------------------------------------------------------
   // input synchronisers: trig_wait, frame_active, fval, lnk_clk
   // ---------------------------------------------------------------
   logic [3:0]   s1_reg;
   logic [3:0]   s2_reg;
   logic [3:0]   s3_reg;
   logic         tw_s;
   logic         fval_fall;
   logic         lclk_rise;

   assign tw_s      = s2_reg[0];
   assign fval_fall = ~s2_reg[2] & s3_reg[2];
   assign lclk_rise = s2_reg[3] & ~s3_reg[3];

   // ---------------------------------------------------------------
   // registers and decode
   // ---------------------------------------------------------------
   logic         auto_reg;
   tiat_layout_t layout_reg;
   logic         clk60_reg;
   logic [23:0]  period_reg;
   logic [23:0]  expmax_reg;
   logic [15:0]  frames_reg;
   logic [23:0]  lcnt_reg;
   logic [23:0]  lcnt_last_reg;
   logic [31:0]  rdata_reg;
   logic [31:0]  rd_mux;
   logic         wr_ctrl;
   logic         fire_wr;
   logic [23:0]  guard;
   logic [23:0]  eff_period;

   assign wr_ctrl = i_wr & (i_addr == `TIAT_A_CTRL);
   assign fire_wr = wr_ctrl & i_wdata[`TIAT_F_FIRE];
   assign guard   = (layout_reg == TIAT_TWO) ? (clk60_reg ? `TIAT_X2_60 : `TIAT_X2_80)
                                             : (clk60_reg ? `TIAT_X4_60 : `TIAT_X4_80);
   // period never shorter than longest exposure plus readout guard
   assign eff_period = (period_reg < expmax_reg + guard) ? expmax_reg + guard
                                                         : period_reg;
   assign rd_mux = (i_addr == `TIAT_A_CTRL)    ? {27'h0, clk60_reg, layout_reg, auto_reg, 1'b0} :
                   (i_addr == `TIAT_A_PERIOD)  ? {8'h00, period_reg} :
                   (i_addr == `TIAT_A_EXPMAX)  ? {8'h00, expmax_reg} :
                   (i_addr == `TIAT_A_STATUS)  ? {28'h0, s2_reg} :
                   (i_addr == `TIAT_A_FRAMES)  ? {16'h0000, frames_reg} :
                   (i_addr == `TIAT_A_LINKCNT) ? {8'h00, lcnt_last_reg} : 32'h00000000;
   assign o_rdata = rdata_reg;

   // ---------------------------------------------------------------
   // trigger generation
   // ---------------------------------------------------------------
   logic         req_reg;
   logic         trig_reg;
   logic [5:0]   pw_reg;
   logic [4:0]   pre_reg;
   logic [23:0]  pcnt_reg;
   logic         tick;
   logic         auto_due;
   logic         launch;

   assign tick     = (pre_reg == 5'(`TIAT_US_CYC - 1));
   assign auto_due = auto_reg & tick & (pcnt_reg >= eff_period - 24'h1);
   assign launch   = req_reg & tw_s & ~trig_reg;
   assign lnk.trig = trig_reg;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s1_reg        <= 4'h0;
         s2_reg        <= 4'h0;
         s3_reg        <= 4'h0;
         auto_reg      <= 1'b0;
         layout_reg    <= TIAT_FOUR;
         clk60_reg     <= 1'b0;
         period_reg    <= 24'h000000;
         expmax_reg    <= 24'h000000;
         frames_reg    <= 16'h0000;
         lcnt_reg      <= 24'h000000;
         lcnt_last_reg <= 24'h000000;
         rdata_reg     <= 32'h00000000;
      end else if (i_ce) begin
         s1_reg    <= {lnk.lnk_clk, lnk.fval, lnk.frame_active, lnk.trig_wait};
         s2_reg    <= s1_reg;
         s3_reg    <= s2_reg;
         rdata_reg <= i_rd ? rd_mux : 32'h00000000;
         if (wr_ctrl) begin
            auto_reg   <= i_wdata[`TIAT_F_AUTO];
            layout_reg <= tiat_layout_t'(i_wdata[`TIAT_F_LAYOUT]);
            clk60_reg  <= i_wdata[`TIAT_F_CLK60];
         end
         if (i_wr && i_addr == `TIAT_A_PERIOD)
            period_reg <= i_wdata[23:0];
         if (i_wr && i_addr == `TIAT_A_EXPMAX)
            expmax_reg <= i_wdata[23:0];
         if (fval_fall) begin
            frames_reg    <= frames_reg + 16'h1;
            lcnt_last_reg <= lcnt_reg;
            lcnt_reg      <= 24'h000000;
         end else if (lclk_rise && s2_reg[2]) begin
            lcnt_reg <= lcnt_reg + 24'h1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         req_reg  <= 1'b0;
         trig_reg <= 1'b0;
         pw_reg   <= 6'h00;
         pre_reg  <= 5'h00;
         pcnt_reg <= 24'h000000;
      end else if (i_ce) begin
         pre_reg <= tick ? 5'h00 : pre_reg + 5'h1;
         if (launch)
            pcnt_reg <= 24'h000000;
         else if (tick && pcnt_reg != 24'hffffff)
            pcnt_reg <= pcnt_reg + 24'h1;
         // a new request wins over the clear by launch
         if (fire_wr || auto_due)
            req_reg <= 1'b1;
         else if (launch)
            req_reg <= 1'b0;
         if (launch) begin
            trig_reg <= 1'b1;
            pw_reg   <= 6'h00;
         end else if (trig_reg) begin
            pw_reg <= pw_reg + 6'h1;
            if (pw_reg == 6'(`TIAT_CYC(`TIAT_PULSE_NS) - 1))
               trig_reg <= 1'b0;
         end
      end
   end
endmodule
